// File: pkg/rshc_pkg.sv
`default_nettype none

package rshc_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned DEBOUNCE_US = 2000;
	localparam int unsigned SHUTDOWN_MS = 4000;
	// Least time rounds up, plus one so the debounce is strictly more than 2 ms
	localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000)) + 1;
	// Longest time rounds down
	localparam longint unsigned SHUTDOWN_CYC = longint'(SHUTDOWN_MS) * longint'(CLK_HZ / 1000);
	localparam int unsigned STRAP_SETTLE_CYC = 16;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [1:0] EMPH_0DB = 2'h0;
	localparam logic [1:0] EMPH_1P5DB = 2'h1;
	localparam logic [1:0] EMPH_2P5DB = 2'h2;
	localparam logic [1:0] EQ_3DB = 2'h0;
	localparam logic [1:0] EQ_6DB = 2'h1;
	localparam logic [1:0] EQ_9DB = 2'h2;
	localparam logic [1:0] EQ_12DB = 2'h3;
	localparam logic [1:0] CLK_EQ_FIXED = EQ_3DB;
	localparam int unsigned SWING_MV = 500;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] RST_EMPH = EMPH_0DB;
	localparam logic [1:0] RST_EQ = EQ_3DB;

	typedef enum logic [1:0] {
		RSHC_ST_STANDBY,
		RSHC_ST_DEBOUNCE,
		RSHC_ST_ACTIVE,
		RSHC_ST_SHUTDLY
	} rshc_hp_state_t;
endpackage : rshc_pkg

`default_nettype wire

// File: rtl/rshc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module rshc_ctrl #(
	parameter int unsigned NUM_DATA_CH = 3,
	parameter longint unsigned SHUTDOWN_CYCLES = rshc_pkg::SHUTDOWN_CYC,
	parameter int unsigned DEBOUNCE_CYCLES = rshc_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Mode pins
	input wire logic i_interface_select,
	input wire logic i_side_channel_select,
	// Shared strap pins
	input wire logic i_plug_output_style_strap,
	input wire logic i_termination_bias_strap,
	input wire logic i_output_termination_strap,
	input wire logic i_emphasis_strap_hi,
	input wire logic i_emphasis_strap_lo,
	input wire logic i_equalizer_strap_low,
	input wire logic i_equalizer_strap_high,
	// Plug detect and activity
	input wire logic i_downstream_plug_detect,
	input wire logic i_clock_present,
	input wire logic i_output_disable,
	input wire logic i_squelch_pullup_sel,
	// Mode outputs
	output logic o_serial_mode,
	output logic o_side_buffer_active,
	output logic [3:0] o_serial_addr,
	output logic o_bias_to_supply,
	// Upstream plug indicate pin
	output logic o_upstream_plug_indicate,
	output logic o_upstream_plug_indicate_oe_n,
	// Data channel settings
	output logic [1:0] o_data_emphasis,
	output logic [1:0] o_data_eq,
	output logic o_data_double_term,
	output logic [NUM_DATA_CH-1:0] o_data_out_en,
	output logic [NUM_DATA_CH-1:0] o_data_pullup,
	output logic [NUM_DATA_CH-1:0] o_data_cdr_en,
	// Clock channel settings
	output logic [1:0] o_clk_eq,
	output logic [1:0] o_clk_emphasis,
	output logic o_clk_double_term,
	output logic o_clk_out_en,
	// Power control
	output logic o_powerdown_res_en,
	output logic o_standby,
	output logic o_core_power_en,
	output logic o_always_on_power_en
);

	if (NUM_DATA_CH < 1 || DEBOUNCE_CYCLES < 1 || SHUTDOWN_CYCLES < 1 ||
		SHUTDOWN_CYCLES > 64'h0000_00ff_ffff_fffe || rshc_pkg::STRAP_SETTLE_CYC > 31) begin : g_bad_param
		$error("rshc_ctrl: bad parameter");
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	assign async_in = {i_interface_select, i_side_channel_select, i_plug_output_style_strap,
		i_termination_bias_strap, i_output_termination_strap, i_emphasis_strap_hi,
		i_emphasis_strap_lo, i_equalizer_strap_low, i_equalizer_strap_high,
		i_downstream_plug_detect, i_clock_present};

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
		end
	end

	logic s_ifsel, s_scsel, s_style, s_bias, s_term, s_emph_hi, s_emph_lo, s_eq_lo, s_eq_hi;
	logic s_hpd, s_clk_ok;
	assign {s_ifsel, s_scsel, s_style, s_bias, s_term, s_emph_hi, s_emph_lo, s_eq_lo, s_eq_hi,
		s_hpd, s_clk_ok} = sync2_r;

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	logic [4:0] settle_r, settle_nxt;
	logic latched_r, latched_nxt;
	logic serial_r, serial_nxt;
	logic scbuf_r, scbuf_nxt;
	logic style_r, style_nxt;
	logic bias_r, bias_nxt;
	logic term_r, term_nxt;
	logic [1:0] emph_r, emph_nxt;
	logic [1:0] eq_r, eq_nxt;
	logic [3:0] addr_r, addr_nxt;

	always_comb begin
		settle_nxt = settle_r;
		latched_nxt = latched_r;
		serial_nxt = serial_r;
		scbuf_nxt = scbuf_r;
		style_nxt = style_r;
		bias_nxt = bias_r;
		term_nxt = term_r;
		emph_nxt = emph_r;
		eq_nxt = eq_r;
		addr_nxt = addr_r;
		if (!latched_r) begin
			if (settle_r == 5'(rshc_pkg::STRAP_SETTLE_CYC)) begin
				latched_nxt = 1'b1;
				serial_nxt = s_ifsel;
				scbuf_nxt = s_scsel;
				style_nxt = s_style;
				bias_nxt = s_bias;
				addr_nxt = {s_eq_hi, s_eq_lo, s_emph_hi, s_term};
				term_nxt = s_term;
				if (s_emph_hi && s_emph_lo) begin
					emph_nxt = rshc_pkg::EMPH_2P5DB;
				end else if (!s_emph_hi && !s_emph_lo) begin
					emph_nxt = rshc_pkg::EMPH_0DB;
				end else begin
					emph_nxt = rshc_pkg::EMPH_1P5DB;
				end
				eq_nxt = {s_eq_hi, s_eq_lo};
			end else begin
				settle_nxt = settle_r + 5'h01;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			settle_r <= 5'h00;
			latched_r <= 1'b0;
			serial_r <= 1'b0;
			scbuf_r <= 1'b0;
			style_r <= 1'b0;
			bias_r <= 1'b0;
			term_r <= 1'b0;
			emph_r <= rshc_pkg::RST_EMPH;
			eq_r <= rshc_pkg::RST_EQ;
			addr_r <= 4'h0;
		end else begin
			settle_r <= settle_nxt;
			latched_r <= latched_nxt;
			serial_r <= serial_nxt;
			scbuf_r <= scbuf_nxt;
			style_r <= style_nxt;
			bias_r <= bias_nxt;
			term_r <= term_nxt;
			emph_r <= emph_nxt;
			eq_r <= eq_nxt;
			addr_r <= addr_nxt;
		end
	end

	// ----------------------------------------
	// Plug detect sequencer
	// ----------------------------------------
	rshc_pkg::rshc_hp_state_t st_r, st_nxt;
	logic [39:0] cnt_r, cnt_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			rshc_pkg::RSHC_ST_STANDBY: begin
				cnt_nxt = 40'h0;
				if (s_hpd) begin
					st_nxt = rshc_pkg::RSHC_ST_DEBOUNCE;
					cnt_nxt = 40'h1;
				end
			end
			rshc_pkg::RSHC_ST_DEBOUNCE: begin
				if (!s_hpd) begin
					st_nxt = rshc_pkg::RSHC_ST_STANDBY;
					cnt_nxt = 40'h0;
				end else if (cnt_r >= 40'(DEBOUNCE_CYCLES)) begin
					st_nxt = rshc_pkg::RSHC_ST_ACTIVE;
					cnt_nxt = 40'h0;
				end else begin
					cnt_nxt = cnt_r + 40'h1;
				end
			end
			rshc_pkg::RSHC_ST_ACTIVE: begin
				cnt_nxt = 40'h0;
				if (!s_hpd) begin
					st_nxt = rshc_pkg::RSHC_ST_SHUTDLY;
					cnt_nxt = 40'h1;
				end
			end
			rshc_pkg::RSHC_ST_SHUTDLY: begin
				if (s_hpd) begin
					st_nxt = rshc_pkg::RSHC_ST_ACTIVE;
					cnt_nxt = 40'h0;
				end else if (cnt_r >= 40'(SHUTDOWN_CYCLES)) begin
					st_nxt = rshc_pkg::RSHC_ST_STANDBY;
					cnt_nxt = 40'h0;
				end else begin
					cnt_nxt = cnt_r + 40'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= rshc_pkg::RSHC_ST_STANDBY;
			cnt_r <= 40'h0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	logic standby_nxt, active;
	logic [NUM_DATA_CH-1:0] den_nxt, dpu_nxt, cdr_nxt;
	logic uo_nxt, uoe_n_nxt, ck_en_nxt, pdres_nxt;

	assign standby_nxt = (st_r == rshc_pkg::RSHC_ST_STANDBY) || (st_r == rshc_pkg::RSHC_ST_DEBOUNCE);
	// disabled or standby means outputs off
	assign active = !standby_nxt && !i_output_disable && latched_r;
	assign pdres_nxt = !s_hpd;
	assign ck_en_nxt = active;

	genvar g;
	generate
		for (g = 0; g < NUM_DATA_CH; g++) begin : g_ch
			assign den_nxt[g] = active && s_clk_ok;
			assign dpu_nxt[g] = active && !s_clk_ok && i_squelch_pullup_sel;
			assign cdr_nxt[g] = active && s_clk_ok;
		end
	endgenerate

	always_comb begin
		uo_nxt = 1'b0;
		uoe_n_nxt = 1'b1;
		if (latched_r && !serial_r) begin
			if (style_r) begin
				uoe_n_nxt = !s_hpd ? 1'b0 : 1'b1;
			end else begin
				uo_nxt = !s_hpd;
				uoe_n_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_standby <= 1'b1;
			o_data_out_en <= '0;
			o_data_pullup <= '0;
			o_data_cdr_en <= '0;
			o_clk_out_en <= 1'b0;
			o_powerdown_res_en <= 1'b1;
			o_upstream_plug_indicate <= 1'b0;
			o_upstream_plug_indicate_oe_n <= 1'b1;
		end else begin
			o_standby <= standby_nxt;
			o_data_out_en <= den_nxt;
			o_data_pullup <= dpu_nxt;
			o_data_cdr_en <= cdr_nxt;
			o_clk_out_en <= ck_en_nxt;
			o_powerdown_res_en <= pdres_nxt;
			o_upstream_plug_indicate <= uo_nxt;
			o_upstream_plug_indicate_oe_n <= uoe_n_nxt;
		end
	end

	assign o_serial_mode = serial_r;
	assign o_side_buffer_active = scbuf_r;
	// address bits only in serial mode
	assign o_serial_addr = serial_r ? addr_r : 4'h0;
	assign o_bias_to_supply = !serial_r && bias_r;
	assign o_data_emphasis = emph_r;
	assign o_data_eq = eq_r;
	assign o_data_double_term = term_r;
	assign o_clk_eq = rshc_pkg::CLK_EQ_FIXED;
	assign o_clk_emphasis = rshc_pkg::EMPH_0DB;
	assign o_clk_double_term = 1'b0;
	assign o_core_power_en = !o_standby && !i_output_disable;
	assign o_always_on_power_en = 1'b1;

endmodule : rshc_ctrl

`default_nettype wire

// File: verif/rshc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rshc_ctrl_asserts #(
	parameter int unsigned NUM_DATA_CH = 3,
	parameter longint unsigned SHUTDOWN_CYCLES = 50,
	parameter int unsigned DEBOUNCE_CYCLES = 20
) (
	// Clock and inputs
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_downstream_plug_detect,
	input wire logic i_clock_present,
	input wire logic i_output_disable,
	input wire logic i_squelch_pullup_sel,
	// Watched outputs
	input wire logic o_serial_mode,
	input wire logic o_upstream_plug_indicate_oe_n,
	input wire logic [NUM_DATA_CH-1:0] o_data_out_en,
	input wire logic [NUM_DATA_CH-1:0] o_data_pullup,
	input wire logic [1:0] o_clk_eq,
	input wire logic [1:0] o_clk_emphasis,
	input wire logic o_clk_double_term,
	input wire logic o_clk_out_en,
	input wire logic o_powerdown_res_en,
	input wire logic o_standby,
	input wire logic o_core_power_en
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// Plug high and low run lengths
	logic [31:0] hi_r, hi_nxt, lo_r, lo_nxt;
	always_comb begin
		hi_nxt = i_downstream_plug_detect ? hi_r + 32'(~&hi_r) : 32'h0;
		lo_nxt = i_downstream_plug_detect ? 32'h0 : lo_r + 32'(~&lo_r);
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			hi_r <= 32'h0;
			lo_r <= 32'h0;
		end else begin
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
		end
	end
	sequence s_plug_low;
		!i_downstream_plug_detect [*4];
	endsequence
	sequence s_squelched;
		(!i_clock_present && !i_output_disable && $stable(i_squelch_pullup_sel)) [*4];
	endsequence
	a_clk_chan_fixed: assert property (o_clk_eq == 2'h0 && o_clk_emphasis == 2'h0 && !o_clk_double_term)
		else $error("clock channel settings not fixed");
	a_pdres_plug_low: assert property (s_plug_low |-> o_powerdown_res_en)
		else $error("power-down resistors off with plug low");
	a_disable_hiz: assert property (i_output_disable [*2] |-> o_data_out_en == '0 && !o_clk_out_en)
		else $error("outputs driven while disabled");
	a_standby_dark: assert property (o_standby |-> o_data_out_en == '0 && !o_core_power_en)
		else $error("outputs or core powered in standby");
	a_debounce_min: assert property ($fell(o_standby) |-> hi_r >= DEBOUNCE_CYCLES)
		else $error("standby left before debounce");
	a_debounce_max: assert property (hi_r == DEBOUNCE_CYCLES + 8 |-> !o_standby)
		else $error("standby kept after debounce");
	a_shutdown_max: assert property (lo_r == SHUTDOWN_CYCLES + 8 |-> o_standby)
		else $error("no standby after shutdown delay");
	a_serial_release: assert property (o_serial_mode |-> o_upstream_plug_indicate_oe_n)
		else $error("plug indicate driven in serial mode");
	a_squelch_force: assert property (s_squelched ##0 !o_standby |->
		o_data_out_en == '0 && o_data_pullup == {NUM_DATA_CH{i_squelch_pullup_sel}})
		else $error("squelch forcing wrong");
endmodule : rshc_ctrl_asserts
`default_nettype wire

// File: verif/rshc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rshc_ctrl_bench;
	localparam int DB = 20;
	localparam int SD = 50;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [8:0] st = 9'h000;
	logic plug = 1'b0;
	logic ckp = 1'b1;
	logic dis = 1'b0;
	logic sel = 1'b0;
	wire logic pd, upi, upi_oe_n, lvl, ser, side, bias, dterm, stby, pdres, aon, ckoe, core;
	wire logic [3:0] addr;
	wire logic [1:0] emph, eq;
	wire logic [2:0] oen, pu, cdr;
	int num_errors = 0;
	int checks_done = 0;
	logic [8:0] tbl [5] = '{9'h0b0, 9'h045, 9'h0ea, 9'h01f, 9'h17a};
	always #5 clk = ~clk;
	rshc_ctrl #(.SHUTDOWN_CYCLES(SD), .DEBOUNCE_CYCLES(DB)) i_rshc_ctrl (
		.i_mclk(clk), .i_rstn(rstn), .i_interface_select(st[8]), .i_side_channel_select(st[7]),
		.i_plug_output_style_strap(st[6]), .i_termination_bias_strap(st[5]),
		.i_output_termination_strap(st[4]), .i_emphasis_strap_hi(st[3]), .i_emphasis_strap_lo(st[2]),
		.i_equalizer_strap_high(st[1]), .i_equalizer_strap_low(st[0]), .i_downstream_plug_detect(pd),
		.i_clock_present(ckp), .i_output_disable(dis), .i_squelch_pullup_sel(sel),
		.o_serial_mode(ser), .o_side_buffer_active(side), .o_serial_addr(addr), .o_bias_to_supply(bias),
		.o_upstream_plug_indicate(upi), .o_upstream_plug_indicate_oe_n(upi_oe_n),
		.o_data_emphasis(emph), .o_data_eq(eq), .o_data_double_term(dterm), .o_data_out_en(oen),
		.o_data_pullup(pu), .o_data_cdr_en(cdr), .o_clk_eq(), .o_clk_emphasis(), .o_clk_double_term(),
		.o_clk_out_en(ckoe), .o_powerdown_res_en(pdres), .o_standby(stby), .o_core_power_en(core),
		.o_always_on_power_en(aon)
	);
	rshc_plug_model i_rshc_plug_model (
		.i_mclk(clk), .i_plug(plug), .o_downstream_plug_detect(pd),
		.i_upi(upi), .i_upi_oe_n(upi_oe_n), .o_upi_level(lvl)
	);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task summarize;
		if (num_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task rst_straps(input logic [8:0] s);
		st <= s;
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (22) @(posedge clk);
	endtask : rst_straps
	task t_straps(input logic [8:0] s);
		logic [1:0] em;
		em = (s[3:2] == 2'b00) ? 2'h0 : (s[3:2] == 2'b11) ? 2'h2 : 2'h1;
		rst_straps(s);
		chk({ser, side}, s[8:7]);
		if (s[8]) begin
			chk({addr, upi_oe_n, bias}, {s[1], s[0], s[3], s[4], 2'b10});
		end else begin
			chk({bias, emph, dterm, eq, addr}, {s[5], em, s[4], s[1:0], 4'h0});
			chk({15'h0000, lvl}, {15'h0000, !s[6]});
		end
		st <= ~s;
		repeat (4) @(posedge clk);
		chk({ser, side, eq}, {s[8:7], s[1:0]});
	endtask : t_straps
	task t_hotplug;
		rst_straps(9'h0b0);
		plug <= 1'b1;
		repeat (DB - 8) @(posedge clk);
		plug <= 1'b0;
		repeat (10) @(posedge clk);
		chk({stby, pdres}, 2'b11);
		plug <= 1'b1;
		repeat (DB + 8) @(posedge clk);
		chk({stby, pdres, oen, lvl, cdr, ckoe, core, aon}, 12'h3bf);
	endtask : t_hotplug
	task t_squelch;
		ckp <= 1'b0;
		sel <= 1'b1;
		repeat (6) @(posedge clk);
		chk({oen, pu, cdr}, 9'h038);
		sel <= 1'b0;
		repeat (6) @(posedge clk);
		chk({oen, pu}, 6'h00);
		ckp <= 1'b1;
		dis <= 1'b1;
		repeat (6) @(posedge clk);
		chk(oen, 3'h0);
		dis <= 1'b0;
		repeat (6) @(posedge clk);
		chk(oen, 3'h7);
	endtask : t_squelch
	task t_unplug;
		plug <= 1'b0;
		repeat (10) @(posedge clk);
		chk(pdres, 1'b1);
		plug <= 1'b1;
		repeat (6) @(posedge clk);
		chk({stby, oen}, 4'h7);
		plug <= 1'b0;
		repeat (SD + 8) @(posedge clk);
		chk({stby, oen, cdr, core, aon}, 9'h101);
	endtask : t_unplug
	initial begin
		foreach (tbl[k]) t_straps(tbl[k]);
		t_hotplug();
		t_squelch();
		t_unplug();
		summarize();
	end
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule : rshc_ctrl_bench
bind rshc_ctrl rshc_ctrl_asserts #(.NUM_DATA_CH(NUM_DATA_CH), .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES),
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_chk (
	.i_mclk(i_mclk), .i_rstn(i_rstn), .i_downstream_plug_detect(i_downstream_plug_detect),
	.i_clock_present(i_clock_present), .i_output_disable(i_output_disable),
	.i_squelch_pullup_sel(i_squelch_pullup_sel), .o_serial_mode(o_serial_mode),
	.o_upstream_plug_indicate_oe_n(o_upstream_plug_indicate_oe_n), .o_data_out_en(o_data_out_en),
	.o_data_pullup(o_data_pullup), .o_clk_eq(o_clk_eq), .o_clk_emphasis(o_clk_emphasis),
	.o_clk_double_term(o_clk_double_term), .o_clk_out_en(o_clk_out_en),
	.o_powerdown_res_en(o_powerdown_res_en), .o_standby(o_standby), .o_core_power_en(o_core_power_en)
);
`default_nettype wire

// File: verif/rshc_plug_model.sv
`timescale 1ns/1ps
`default_nettype none
module rshc_plug_model (
	// Clock and command
	input wire logic i_mclk,
	input wire logic i_plug,
	// Plug lines
	output logic o_downstream_plug_detect = 1'b0,
	input wire logic i_upi,
	input wire logic i_upi_oe_n,
	output logic o_upi_level
);
	assign o_upi_level = i_upi_oe_n ? 1'b1 : i_upi;
	always @(posedge i_mclk) begin
		o_downstream_plug_detect <= i_plug;
	end
endmodule : rshc_plug_model
`default_nettype wire
